/* File: ccr_pkg.sv */
// Constants and types shared by the charger control register bank
//
// Operation
// - Ship action waits 10 s when delay bit is 0, acts at once when 1.
// - Ship action code: 0 idle, 1 shutdown, 2 ship mode, 3 power reset.
// - Master disable holds both input gate-driver enables at 0.
// - Reverse output enable; cleared by register reset and watchdog expiry.
// - Pulse-frequency disables; reverse one also cleared by watchdog expiry.
// - Wake pin low for 1 s (bit 0) or 15 ms (bit 1) leaves ship mode.
// - Precharge linear disable bit; cleared by watchdog or register reset.
// - Out-of-audio disables; reverse one also cleared by watchdog expiry.
// - Control register three resets to all zeros.
// - Gate enables switch drivers; absent FET pair at power-on locks bit 0.
// - Frequency bit 0 is 1.5 MHz, 1 is 750 kHz; reset value from strap.
// - Status output disable bit; cleared by watchdog or register reset.
// - System short protect disable bit; 0 keeps hiccup protection on.
// - Reverse undervoltage protect disable bit; 0 keeps protection on.
// - Forced limit detect accepts 1 only when battery above minimum.
// - Detection stops switching, measures, updates limit, clears trigger.
// - Input overcurrent enable resets to 1; writing 0 disables it.
// - Watchdog period field: off, 0.5,1,2,20,40,80,160 s; host must service.
// - Writing kick restarts the watchdog; kick bit returns to 0 itself.
package ccr_pkg;

    // ==========================================================
    // Register offsets and reset values
    localparam logic [7:0] CCR_OFS_CTRL1 = 8'h10;
    localparam logic [7:0] CCR_OFS_CTRL2 = 8'h11;
    localparam logic [7:0] CCR_OFS_CTRL3 = 8'h12;
    localparam logic [7:0] CCR_OFS_CTRL4 = 8'h13;
    localparam logic [7:0] CCR_RST_CTRL1 = 8'h05;
    localparam logic [7:0] CCR_RST_CTRL2 = 8'h00;
    localparam logic [7:0] CCR_RST_CTRL3 = 8'h00;
    localparam logic [7:0] CCR_RST_CTRL4 = 8'h01;
    // Bits cleared by watchdog expiry
    localparam logic [7:0] CCR_WD_CTRL3  = 8'h66;
    localparam logic [7:0] CCR_WD_CTRL4  = 8'h10;

    // ==========================================================
    // Field positions
    localparam int C1_KICK = 3;
    localparam int C1_WD_HI = 2;
    localparam int C2_SHIP_HI = 2;
    localparam int C2_SHIP_LO = 1;
    localparam int C2_NO_DELAY = 0;
    localparam int C3_MASTER = 7;
    localparam int C3_REV_EN = 6;
    localparam int C3_REV_PFM = 5;
    localparam int C3_FWD_PFM = 4;
    localparam int C3_WAKE_SEL = 3;
    localparam int C3_LIN_DIS = 2;
    localparam int C3_REV_OOA = 1;
    localparam int C3_FWD_OOA = 0;
    localparam int C4_FET2 = 7;
    localparam int C4_FET1 = 6;
    localparam int C4_FREQ = 5;
    localparam int C4_STAT = 4;
    localparam int C4_SYS = 3;
    localparam int C4_UV = 2;
    localparam int C4_DET = 1;
    localparam int C4_OCP = 0;

    // ==========================================================
    // Ship action codes
    localparam logic [1:0] SHIP_IDLE = 2'h0;
    localparam logic [1:0] SHIP_SHUTDOWN = 2'h1;
    localparam logic [1:0] SHIP_SHIP = 2'h2;
    localparam logic [1:0] SHIP_RESET = 2'h3;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int SHIP_DELAY_S = 10;
    localparam int SHIP_DELAY_MS = SHIP_DELAY_S * MS_PER_S;
    localparam int WAKE_LONG_S = 1;
    localparam int WAKE_LONG_MS = WAKE_LONG_S * MS_PER_S;
    localparam int WAKE_SHORT_MS = 15;
    localparam int T_W = 18;

    typedef enum logic [0:0] {SH_IDLE, SH_WAIT} ccr_ship_t;
    typedef enum logic [0:0] {DT_IDLE, DT_WAIT} ccr_det_t;

    // Watchdog period in ms, zero meaning disabled
    function automatic logic [T_W-1:0] ccr_wd_ms(input logic [2:0] sel);
        case (sel)
            3'h1: ccr_wd_ms = 18'h001F4;
            3'h2: ccr_wd_ms = 18'h003E8;
            3'h3: ccr_wd_ms = 18'h007D0;
            3'h4: ccr_wd_ms = 18'h04E20;
            3'h5: ccr_wd_ms = 18'h09C40;
            3'h6: ccr_wd_ms = 18'h13880;
            3'h7: ccr_wd_ms = 18'h27100;
            default: ccr_wd_ms = 18'h00000;
        endcase
    endfunction : ccr_wd_ms

endpackage : ccr_pkg

/* File: ccr_tick.sv */
// Millisecond tick generator for the charger control register bank
`timescale 1ns/1ns
module ccr_tick #(
    parameter int unsigned CYC = 50000
) (
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    input  wire logic ce_i,
    output logic      tick_o
);
    logic [15:0] cnt;

    // ==========================================================
    // Divider; one-cycle pulse every CYC enabled cycles
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            cnt    <= 16'h0000;
            tick_o <= 1'b0;
        end
        else if (ce_i)
        begin
            tick_o <= (cnt == 16'(CYC - 1));
            if (cnt == 16'(CYC - 1))
                cnt <= 16'h0000;
            else
                cnt <= cnt + 16'h0001;
        end
    end
endmodule : ccr_tick

/* File: ccr_bank.sv */
// Charger control register bank with its timers and detection sequencer
`timescale 1ns/1ns
module ccr_bank #(
    parameter int unsigned CYC_MS = ccr_pkg::CYC_PER_MS
) (
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ce_i,
    input  wire logic       reg_reset_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       programming_strap_pin_i,
    input  wire logic       fet1_present_i,
    input  wire logic       fet2_present_i,
    input  wire logic       vbat_above_min_i,
    input  wire logic       adc_done_i,
    input  wire logic [7:0] adc_data_i,
    input  wire logic       wake_pin_i,
    output logic            reverse_output_enable_o,
    output logic            reverse_pulse_freq_disable_o,
    output logic            forward_pulse_freq_disable_o,
    output logic            wake_hold_time_select_o,
    output logic            precharge_linear_disable_o,
    output logic            reverse_out_of_audio_disable_o,
    output logic            forward_out_of_audio_disable_o,
    output logic            input_fet1_gate_enable_o,
    output logic            input_fet2_gate_enable_o,
    output logic            switching_frequency_select_o,
    output logic            status_output_disable_o,
    output logic            system_short_protect_disable_o,
    output logic            reverse_undervoltage_protect_disable_o,
    output logic            input_overcurrent_enable_o,
    output logic            switching_stop_o,
    output logic            adc_start_o,
    output logic            limit_update_o,
    output logic      [7:0] input_voltage_limit_o,
    output logic            enter_shutdown_o,
    output logic            enter_ship_mode_o,
    output logic            system_reset_o,
    output logic            wake_exit_o,
    output logic            watchdog_expired_o
);
    import ccr_pkg::*;

    logic [7:0]     ctrl1;
    logic [7:0]     ctrl2;
    logic [7:0]     ctrl3;
    logic [7:0]     ctrl4;
    logic           tick;
    logic           wr1;
    logic           wr2;
    logic           wr3;
    logic           wr4;
    logic           wd_exp;
    logic           next_master;
    logic [1:0]     present;
    logic [1:0]     lock;
    logic           fet1_present_q;
    logic           fet2_present_q;
    logic           init_pend;
    logic [T_W-1:0] wd_cnt;
    logic [T_W-1:0] sh_cnt;
    logic [T_W-1:0] wk_cnt;
    logic [T_W-1:0] wk_need;
    logic [T_W-1:0] wd_need;
    ccr_ship_t      sh_state;
    ccr_det_t       dt_state;
    logic           det_done;
    logic [1:0]     ship_code;

    // ==========================================================
    // Time base
    ccr_tick #(
        .CYC       (CYC_MS)
    ) u_tick (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .tick_o    (tick)
    );

    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Write strobes; all state is frozen while ce_i is low
    assign wr1 = ce_i & reg_wr_i & hit(reg_addr_i, CCR_OFS_CTRL1);
    assign wr2 = ce_i & reg_wr_i & hit(reg_addr_i, CCR_OFS_CTRL2);
    assign wr3 = ce_i & reg_wr_i & hit(reg_addr_i, CCR_OFS_CTRL3);
    assign wr4 = ce_i & reg_wr_i & hit(reg_addr_i, CCR_OFS_CTRL4);

    // Master disable as it will stand after this edge, so a gate bit is
    // never seen high in the cycle the master goes high
    assign next_master = reg_reset_i ? 1'b0 :
                         wr3 ? reg_wdata_i[C3_MASTER] : ctrl3[C3_MASTER];

    // Per-driver lock: master override or pair found absent
    assign present = {fet2_present_q, fet1_present_q};
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_lock
            assign lock[g] = next_master | ~present[g];
        end
    endgenerate

    // ==========================================================
    // Power-on capture of strap and FET presence, one cycle after reset
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            init_pend      <= 1'b1;
            fet1_present_q <= 1'b0;
            fet2_present_q <= 1'b0;
        end
        else if (ce_i && init_pend)
        begin
            init_pend      <= 1'b0;
            fet1_present_q <= fet1_present_i;
            fet2_present_q <= fet2_present_i;
        end
    end

    // ==========================================================
    // Watchdog control register: period and self-clearing kick
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            ctrl1 <= CCR_RST_CTRL1;
        else if (ce_i)
        begin
            if (reg_reset_i)
                ctrl1 <= CCR_RST_CTRL1;
            else if (wr1)
                ctrl1 <= {4'h0, reg_wdata_i[3:0]};
            else if (ctrl1[C1_KICK] || wd_exp)
                ctrl1[C1_KICK] <= 1'b0;
        end
    end

    // Watchdog counter in ms; a kick restarts it
    assign wd_need = ccr_wd_ms(ctrl1[C1_WD_HI:0]);
    assign wd_exp  = tick && (wd_need != 18'h00000)
                     && (wd_cnt >= wd_need - 18'h00001);
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            wd_cnt             <= 18'h00000;
            watchdog_expired_o <= 1'b0;
        end
        else if (ce_i)
        begin
            watchdog_expired_o <= wd_exp;
            if (ctrl1[C1_KICK] || wd_exp || wd_need == 18'h00000)
                wd_cnt <= 18'h00000;
            else if (tick)
                wd_cnt <= wd_cnt + 18'h00001;
        end
    end

    // ==========================================================
    // Ship action register and sequencer
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            ctrl2 <= CCR_RST_CTRL2;
        else if (ce_i)
        begin
            if (reg_reset_i)
                ctrl2 <= CCR_RST_CTRL2;
            else if (wr2)
                ctrl2 <= {5'h00, reg_wdata_i[2:0]};
            else if (enter_shutdown_o | enter_ship_mode_o | system_reset_o)
                ctrl2[C2_SHIP_HI:C2_SHIP_LO] <= SHIP_IDLE;
        end
    end

    assign ship_code = ctrl2[C2_SHIP_HI:C2_SHIP_LO];

    // Fires the action once; clearing the field during the wait cancels
    logic fire;
    assign fire = (ship_code != SHIP_IDLE) && !enter_shutdown_o
                  && !enter_ship_mode_o && !system_reset_o
                  && ((sh_state == SH_IDLE && ctrl2[C2_NO_DELAY])
                  || (sh_state == SH_WAIT && tick
                  && sh_cnt == T_W'(SHIP_DELAY_MS)));
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            sh_state          <= SH_IDLE;
            sh_cnt            <= 18'h00000;
            enter_shutdown_o  <= 1'b0;
            enter_ship_mode_o <= 1'b0;
            system_reset_o    <= 1'b0;
        end
        else if (ce_i)
        begin
            enter_shutdown_o  <= fire && ship_code == SHIP_SHUTDOWN;
            enter_ship_mode_o <= fire && ship_code == SHIP_SHIP;
            system_reset_o    <= fire && ship_code == SHIP_RESET;
            case (sh_state)
                SH_IDLE:
                begin
                    sh_cnt <= 18'h00000;
                    if (ship_code != SHIP_IDLE && !ctrl2[C2_NO_DELAY]
                        && !fire && !enter_shutdown_o
                        && !enter_ship_mode_o && !system_reset_o)
                        sh_state <= SH_WAIT;
                end
                SH_WAIT:
                begin
                    if (ship_code == SHIP_IDLE || fire)
                        sh_state <= SH_IDLE;
                    else if (tick)
                        sh_cnt <= sh_cnt + 18'h00001;
                end
                default: sh_state <= SH_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Control register three
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            ctrl3 <= CCR_RST_CTRL3;
        else if (ce_i)
        begin
            if (reg_reset_i)
                ctrl3 <= CCR_RST_CTRL3;
            else if (wd_exp)
                // Expiry wins only on its own bits; the master stays coherent
                ctrl3 <= (wr3 ? reg_wdata_i : ctrl3) & ~CCR_WD_CTRL3;
            else if (wr3)
                ctrl3 <= reg_wdata_i;
        end
    end

    // ==========================================================
    // Control register four; locked gates store 0, never a pending 1
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            ctrl4 <= CCR_RST_CTRL4;
        else if (ce_i)
        begin
            if (init_pend)
                ctrl4[C4_FREQ] <= programming_strap_pin_i;
            if (reg_reset_i)
                ctrl4 <= {1'b0, 1'b0, ctrl4[C4_FREQ], 5'h01};
            else
            begin
                if (wr4)
                begin
                    ctrl4[C4_FREQ] <= reg_wdata_i[C4_FREQ];
                    ctrl4[C4_SYS]  <= reg_wdata_i[C4_SYS];
                    ctrl4[C4_UV]   <= reg_wdata_i[C4_UV];
                    ctrl4[C4_OCP]  <= reg_wdata_i[C4_OCP];
                    ctrl4[C4_STAT] <= reg_wdata_i[C4_STAT];
                end
                if (wd_exp)
                    ctrl4[C4_STAT] <= 1'b0;
                // Gate enables: write masked by lock, lock also clears
                if (lock[1])
                    ctrl4[C4_FET2] <= 1'b0;
                else if (wr4)
                    ctrl4[C4_FET2] <= reg_wdata_i[C4_FET2];
                if (lock[0])
                    ctrl4[C4_FET1] <= 1'b0;
                else if (wr4)
                    ctrl4[C4_FET1] <= reg_wdata_i[C4_FET1];
                // Trigger: software set wins over sequencer clear
                if (wr4 && reg_wdata_i[C4_DET] && vbat_above_min_i)
                    ctrl4[C4_DET] <= 1'b1;
                else if (det_done)
                    ctrl4[C4_DET] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Forced input-limit detection: stop, measure, update, clear
    assign det_done = (dt_state == DT_WAIT) && adc_done_i;
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            dt_state              <= DT_IDLE;
            switching_stop_o      <= 1'b0;
            adc_start_o           <= 1'b0;
            limit_update_o        <= 1'b0;
            input_voltage_limit_o <= 8'h00;
        end
        else if (ce_i)
        begin
            adc_start_o    <= 1'b0;
            limit_update_o <= 1'b0;
            case (dt_state)
                DT_IDLE:
                    if (ctrl4[C4_DET] && !reg_reset_i)
                    begin
                        dt_state         <= DT_WAIT;
                        switching_stop_o <= 1'b1;
                        adc_start_o      <= 1'b1;
                    end
                DT_WAIT:
                    if (adc_done_i)
                    begin
                        dt_state              <= DT_IDLE;
                        switching_stop_o      <= 1'b0;
                        limit_update_o        <= 1'b1;
                        input_voltage_limit_o <= adc_data_i;
                    end
                default: dt_state <= DT_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Wake detector; one extra tick so the hold is never shorter
    assign wk_need = ctrl3[C3_WAKE_SEL] ? T_W'(WAKE_SHORT_MS)
                                        : T_W'(WAKE_LONG_MS);
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            wk_cnt      <= 18'h00000;
            wake_exit_o <= 1'b0;
        end
        else if (ce_i)
        begin
            wake_exit_o <= !wake_pin_i && tick && wk_cnt == wk_need;
            if (wake_pin_i)
                wk_cnt <= 18'h00000;
            else if (tick && wk_cnt <= wk_need)
                wk_cnt <= wk_cnt + 18'h00001;
        end
    end

    // ==========================================================
    // Read port, registered; unmapped offsets read 0
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            reg_rdata_o <= 8'h00;
        else if (ce_i && reg_rd_i)
        begin
            if (hit(reg_addr_i, CCR_OFS_CTRL1))
                reg_rdata_o <= ctrl1;
            else if (hit(reg_addr_i, CCR_OFS_CTRL2))
                reg_rdata_o <= ctrl2;
            else if (hit(reg_addr_i, CCR_OFS_CTRL3))
                reg_rdata_o <= ctrl3;
            else if (hit(reg_addr_i, CCR_OFS_CTRL4))
                reg_rdata_o <= ctrl4;
            else
                reg_rdata_o <= 8'h00;
        end
    end

    // Field outputs straight from register flops
    assign reverse_output_enable_o = ctrl3[C3_REV_EN];
    assign reverse_pulse_freq_disable_o = ctrl3[C3_REV_PFM];
    assign forward_pulse_freq_disable_o = ctrl3[C3_FWD_PFM];
    assign wake_hold_time_select_o = ctrl3[C3_WAKE_SEL];
    assign precharge_linear_disable_o = ctrl3[C3_LIN_DIS];
    assign reverse_out_of_audio_disable_o = ctrl3[C3_REV_OOA];
    assign forward_out_of_audio_disable_o = ctrl3[C3_FWD_OOA];
    assign input_fet1_gate_enable_o = ctrl4[C4_FET1];
    assign input_fet2_gate_enable_o = ctrl4[C4_FET2];
    assign switching_frequency_select_o = ctrl4[C4_FREQ];
    assign status_output_disable_o = ctrl4[C4_STAT];
    assign system_short_protect_disable_o = ctrl4[C4_SYS];
    assign reverse_undervoltage_protect_disable_o = ctrl4[C4_UV];
    assign input_overcurrent_enable_o = ctrl4[C4_OCP];

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_gate_master: assert property (ctrl3[C3_MASTER] |->
        !input_fet1_gate_enable_o && !input_fet2_gate_enable_o)
        else $error("gate enable high under master disable");
    a_gate_absent: assert property ((!init_pend && !present[0]) |->
        !input_fet1_gate_enable_o)
        else $error("gate one enabled with pair absent");
    a_locked_write: assert property ((wr4 && next_master) |=>
        !input_fet1_gate_enable_o ##1 !input_fet1_gate_enable_o)
        else $error("locked gate write stored");
    a_wd_clear: assert property (watchdog_expired_o |->
        !reverse_output_enable_o && !status_output_disable_o)
        else $error("watchdog fields not cleared");
    a_kick_clear: assert property ((ce_i && ctrl1[C1_KICK] && !wr1)
        |=> !ctrl1[C1_KICK] && wd_cnt == 18'h00000)
        else $error("kick bit not self-cleared");
    a_det_refuse: assert property ((wr4 && !vbat_above_min_i
        && !ctrl4[C4_DET]) |=> !ctrl4[C4_DET])
        else $error("detect trigger accepted at low battery");
    a_det_finish: assert property ((ce_i && det_done && !wr4) |=>
        limit_update_o && !ctrl4[C4_DET] && !switching_stop_o)
        else $error("detection did not finish");
    a_ship_now: assert property ((ce_i && sh_state == SH_IDLE
        && ship_code == SHIP_SHIP && ctrl2[C2_NO_DELAY] && !wr2
        && !reg_reset_i && !enter_ship_mode_o) |=> enter_ship_mode_o)
        else $error("undelayed ship action missing");
    a_ship_wait: assert property ((ce_i && sh_state == SH_IDLE
        && ship_code != SHIP_IDLE && !ctrl2[C2_NO_DELAY] && !wr2)
        |=> !enter_shutdown_o && !enter_ship_mode_o && !system_reset_o)
        else $error("delayed ship action fired early");
    a_reg_reset: assert property ((ce_i && reg_reset_i) |=>
        ctrl3 == 8'h00 && input_overcurrent_enable_o)
        else $error("register reset values wrong");
    a_wake_low: assert property (wake_exit_o |-> $past(!wake_pin_i, 1))
        else $error("wake exit without low pin");

    c_ship: cover property (enter_ship_mode_o);
    c_detect: cover property (limit_update_o);
    c_wake: cover property (wake_exit_o);
    c_wd: cover property (watchdog_expired_o);
endmodule : ccr_bank

/* File: ccr_adc_model.sv */
// ADC stand-in that answers conversion requests after a fixed wait
`timescale 1ns/1ns
module ccr_adc_model #(
    parameter logic [7:0] VAL = 8'hA5
) (
    input  wire logic       clock_i,
    input  wire logic       start_i,
    output logic            done_o = 1'b0,
    output logic      [7:0] data_o = 8'h00
);
    logic [2:0] cnt = 3'h0;
    // Data is valid only with done; it toggles otherwise so stale use shows
    always_ff @(posedge clock_i)
    begin
        done_o <= (cnt == 3'h1);
        cnt    <= start_i ? 3'h4 : cnt - {2'h0, cnt != 3'h0};
        data_o <= (cnt == 3'h1) ? VAL : ~data_o;
    end
endmodule : ccr_adc_model

/* File: charger_control_register_bank_tb.sv */
// Self-checking bench for the charger control register bank
`timescale 1ns/1ns
module charger_control_register_bank_tb;
    import ccr_pkg::*;
    logic       clk  = 1'b0;
    logic       rst  = 1'b1;
    logic       wr   = 1'b0;
    logic       rd   = 1'b0;
    logic       vbat = 1'b0;
    logic       hi   = 1'b1;
    logic       rrst = 1'b0;
    logic       strap = 1'b0;
    logic       fp1  = 1'b1;
    logic       wk   = 1'b1;
    logic       start, done, upd, stop, wdx, fet1, fet2, wx;
    logic [2:0] act;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic [7:0] rdat, adat, lim;
    int         error_cnt = 0;
    int         compares = 0;
    // ==========================================================
    // Clock, device and ADC stand-in; short ms keeps timers brief
    always #10 clk = ~clk;
    ccr_bank #(.CYC_MS(4)) i_dut (.clock_i(clk), .sys_rst_i(rst),
        .ce_i(hi), .reg_reset_i(rrst), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdat), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .programming_strap_pin_i(strap), .fet1_present_i(fp1),
        .fet2_present_i(hi), .vbat_above_min_i(vbat),
        .adc_done_i(done), .adc_data_i(adat), .wake_pin_i(wk),
        .reverse_output_enable_o(), .reverse_pulse_freq_disable_o(),
        .forward_pulse_freq_disable_o(), .wake_hold_time_select_o(),
        .precharge_linear_disable_o(), .reverse_out_of_audio_disable_o(),
        .forward_out_of_audio_disable_o(), .input_fet1_gate_enable_o(fet1),
        .input_fet2_gate_enable_o(fet2), .switching_frequency_select_o(),
        .status_output_disable_o(), .system_short_protect_disable_o(),
        .reverse_undervoltage_protect_disable_o(),
        .input_overcurrent_enable_o(), .switching_stop_o(stop),
        .adc_start_o(start), .limit_update_o(upd),
        .input_voltage_limit_o(lim), .enter_shutdown_o(act[0]),
        .enter_ship_mode_o(act[1]), .system_reset_o(act[2]),
        .wake_exit_o(wx), .watchdog_expired_o(wdx));
    ccr_adc_model i_adc (.clock_i(clk), .start_i(start), .done_o(done),
        .data_o(adat));
    // ==========================================================
    // Shared bus cycles and comparison
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 {wr, addr, wdat} = {1'b1, a, d};
        @(posedge clk);
        #1 wr = 1'b0;
    endtask : wrt
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1 {rd, addr} = {1'b1, a};
        @(posedge clk);
        #1 rd = 1'b0;
        chk(rdat, e);
    endtask : rdc
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    // ==========================================================
    // Scenarios
    task automatic t_gate;
        rdc(CCR_OFS_CTRL3, 8'h00);
        rdc(CCR_OFS_CTRL4, 8'h01);
        wrt(CCR_OFS_CTRL4, 8'hC1);
        rdc(CCR_OFS_CTRL4, 8'hC1);
        wrt(CCR_OFS_CTRL3, 8'h80);
        chk({6'h00, fet2, fet1}, 8'h00);
        wrt(CCR_OFS_CTRL4, 8'hC1);
        wrt(CCR_OFS_CTRL3, 8'h00);
        rdc(CCR_OFS_CTRL4, 8'h01);
        $display("gate lock test done");
    endtask : t_gate
    task automatic t_ship;
        for (int c = 1; c < 4; c++)
        begin
            wrt(CCR_OFS_CTRL2, {5'h00, c[1:0], 1'b1});
            @(posedge clk);
            #1 chk({5'h00, act}, 8'h01 << (c - 1));
            rdc(CCR_OFS_CTRL2, 8'h01);
        end
        // Delayed ship mode must not act early; clearing the field cancels
        wrt(CCR_OFS_CTRL2, 8'h04);
        repeat (8) @(posedge clk);
        #1 chk({5'h00, act}, 8'h00);
        wrt(CCR_OFS_CTRL2, 8'h00);
        rdc(CCR_OFS_CTRL2, 8'h00);
        $display("ship action test done");
    endtask : t_ship
    task automatic t_det;
        logic seen;
        seen = 1'b0;
        wrt(CCR_OFS_CTRL4, 8'h03);
        rdc(CCR_OFS_CTRL4, 8'h01);
        vbat = 1'b1;
        wrt(CCR_OFS_CTRL4, 8'h03);
        for (int n = 0; n < 50 && upd !== 1'b1; n++)
        begin
            @(posedge clk);
            #1 seen = seen | stop;
        end
        chk({upd, stop, seen, 5'h00}, 8'hA0);
        chk(lim, 8'hA5);
        rdc(CCR_OFS_CTRL4, 8'h01);
        $display("forced detection test done");
    endtask : t_det
    task automatic t_wdog;
        wrt(CCR_OFS_CTRL3, 8'h7F);
        wrt(CCR_OFS_CTRL1, 8'h09);
        rdc(CCR_OFS_CTRL1, 8'h01);
        // 500 ms of four-cycle ticks is about 2000 cycles
        for (int n = 0; n < 2100 && wdx !== 1'b1; n++)
            @(posedge clk) #1;
        chk({7'h00, wdx}, 8'h01);
        rdc(CCR_OFS_CTRL3, 8'h19);
        $display("watchdog test done");
    endtask : t_wdog
    task automatic t_wake;
        wrt(CCR_OFS_CTRL3, 8'h08);
        @(posedge clk);
        #1 wk = 1'b0;
        for (int n = 0; n < 80 && wx !== 1'b1; n++)
            @(posedge clk) #1;
        chk({7'h00, wx}, 8'h01);
        wk = 1'b1;
        $display("wake test done");
    endtask : t_wake
    task automatic t_rst;
        wrt(CCR_OFS_CTRL4, 8'h1D);
        @(posedge clk);
        #1 rrst = 1'b1;
        @(posedge clk);
        #1 rrst = 1'b0;
        rdc(CCR_OFS_CTRL3, 8'h00);
        rdc(CCR_OFS_CTRL4, 8'h01);
        // Second power-on: strap high, first FET pair missing
        @(posedge clk);
        #1 {rst, strap, fp1} = 3'b110;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        rdc(CCR_OFS_CTRL4, 8'h21);
        wrt(CCR_OFS_CTRL4, 8'hE1);
        rdc(CCR_OFS_CTRL4, 8'hA1);
        $display("reset and strap test done");
    endtask : t_rst
    // ==========================================================
    // Main sequence and a watchdog against hangs
    initial
    begin
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge clk);
        t_gate;
        t_ship;
        t_det;
        t_wdog;
        t_wake;
        t_rst;
        conclude;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude;
    end
endmodule : charger_control_register_bank_tb
